// [core/pic_ctrl.sv]
// Prioritized interrupt controller between peripheral sources and the core.
// What this block does
// (R1) Registers decode in Y space peripheral ranges
// (R2) Accept sources, present maskable vectors to core
// (R3) Separate block; arbitrate, forward one request
// (R4) Three priority levels configured per source
// (R5) Global counter blocks all sources at once
// (R6) Sources 0-15 low register, 16-27 high
// (R7) Fixed vector; core address is 0x20 plus vector
// (R8) Software stub re-enables before return_from_interrupt; the bench writes the re-enable after the handler model raises done_out
// (R9) Enable bit pair gives off, low, medium, high
// (R10) Request sets flag; forward or write-one clears
// (R11) Forward only at zero counter; counter rules
// (R12) Vector register reads last forwarded vector
// (R13) Equal priority: highest vector number wins
// (R14) Five-bit vector with one-cycle request strobe
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl #(
  parameter int unsigned NUM_SRC = pic_pkg::PIC_NUM_SRC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [NUM_SRC-1:0] source_req_in,
  input wire pic_pkg::pic_bus_s bus_in,
  output logic [15:0] rdata_out,
  output logic hit_out,
  output pic_pkg::pic_req_s core_req_out,
  output logic [2:0] global_enable_counter_out
);
  import pic_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [NUM_SRC-1:0] high_priority_enable_q;
  logic [NUM_SRC-1:0] low_priority_enable_q;
  logic [NUM_SRC-1:0] origin_q;
  logic [4:0] vector_q;
  logic [2:0] global_enable_counter_q;
  logic [2:0] global_enable_counter_d;
  logic strobe_q;
  logic [15:0] rdata_q;
  logic [NUM_SRC-1:0] src_live;
  logic [31:0] wide_wdata;

  // Only sources that have a vector slot are wired.
  assign src_live = source_req_in & PIC_SRC_PRESENT[NUM_SRC-1:0]; // R2 R7
  assign wide_wdata = {bus_in.wdata, bus_in.wdata};

  // Word address decode helper, shared by reads and writes.
  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] r);
    addr_is = (a == r);
  endfunction

  // Write strobes; only the controller slice of the PLL window answers.
  logic in_block;
  assign in_block = bus_in.addr >= PIC_BLOCK_LO && bus_in.addr <= PIC_BLOCK_HI; // R1
  assign hit_out = in_block & (bus_in.rd | bus_in.wr);
  logic wr_ena0_lo, wr_ena1_lo, wr_ena0_hi, wr_ena1_hi, wr_org0, wr_org1, wr_dis, wr_ena;
  assign wr_ena0_lo = bus_in.wr & addr_is(bus_in.addr, PIC_ENA0_LO);
  assign wr_ena1_lo = bus_in.wr & addr_is(bus_in.addr, PIC_ENA1_LO);
  assign wr_ena0_hi = bus_in.wr & addr_is(bus_in.addr, PIC_ENA0_HI);
  assign wr_ena1_hi = bus_in.wr & addr_is(bus_in.addr, PIC_ENA1_HI);
  assign wr_org0 = bus_in.wr & addr_is(bus_in.addr, PIC_ORIGIN0);
  assign wr_org1 = bus_in.wr & addr_is(bus_in.addr, PIC_ORIGIN1);
  assign wr_dis = bus_in.wr & addr_is(bus_in.addr, PIC_GLOB_DIS);
  assign wr_ena = bus_in.wr & addr_is(bus_in.addr, PIC_GLOB_ENA);

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // Scan upward so later, higher-numbered winners overwrite lower ones at equal level.
  pic_pri_e best_pri;
  logic [4:0] best_vec;
  logic any_req;
  always_comb begin
    best_pri = PIC_PRI_OFF;
    best_vec = 5'h00;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (origin_q[i] && pic_pri_e'({high_priority_enable_q[i], low_priority_enable_q[i]}) != PIC_PRI_OFF &&
          pic_pri_e'({high_priority_enable_q[i], low_priority_enable_q[i]}) >= best_pri) begin // R4 R9 R13
        best_pri = pic_pri_e'({high_priority_enable_q[i], low_priority_enable_q[i]});
        best_vec = 5'(i);
      end
    end
    any_req = best_pri != PIC_PRI_OFF;
  end

  // A request leaves only while the counter is zero.
  logic fire;
  assign fire = any_req && global_enable_counter_q == 3'h0; // R3 R5 R11

  // ****************************************************************
  // Enable bit pairs
  // ****************************************************************
  // Low word covers sources 0-15, high word covers 16 and up.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      high_priority_enable_q <= '0;
      low_priority_enable_q <= '0;
    end else begin
      if (wr_ena0_lo) low_priority_enable_q[15:0] <= bus_in.wdata; // R6
      if (wr_ena0_hi) high_priority_enable_q[15:0] <= bus_in.wdata; // R6
      if (wr_ena1_lo) low_priority_enable_q[NUM_SRC-1:16] <= bus_in.wdata[NUM_SRC-17:0]; // R6
      if (wr_ena1_hi) high_priority_enable_q[NUM_SRC-1:16] <= bus_in.wdata[NUM_SRC-17:0]; // R6
    end
  end

  // ****************************************************************
  // Origin flags
  // ****************************************************************
  // A new request outranks both the write clear and the forward clear, so no event is lost.
  logic [NUM_SRC-1:0] clr_mask;
  always_comb begin
    clr_mask = '0;
    if (wr_org0) clr_mask[15:0] = bus_in.wdata;
    if (wr_org1) clr_mask[NUM_SRC-1:16] = wide_wdata[NUM_SRC-17:0];
    if (fire) clr_mask[best_vec] = 1'b1;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      origin_q <= '0;
    end else begin
      origin_q <= (origin_q & ~clr_mask) | src_live; // R10
    end
  end

  // ****************************************************************
  // Global enable counter
  // ****************************************************************
  // A forward and a disable write in one cycle add two; the counter wraps at three bits.
  always_comb begin
    global_enable_counter_d = global_enable_counter_q + 3'(fire) + 3'(wr_dis); // R11
    if (wr_ena && global_enable_counter_d != 3'h0) begin
      global_enable_counter_d = global_enable_counter_d - 3'h1; // R11
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      global_enable_counter_q <= PIC_RST_CNT;
    end else begin
      global_enable_counter_q <= global_enable_counter_d;
    end
  end

  // ****************************************************************
  // Core request and vector register
  // ****************************************************************
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_q <= 1'b0;
      vector_q <= PIC_RST_VEC;
    end else begin
      strobe_q <= fire; // R14
      if (fire) vector_q <= best_vec; // R12
    end
  end
  assign core_req_out.strobe = strobe_q; // R14
  assign core_req_out.vector = vector_q;
  assign core_req_out.address = PIC_VEC_BASE + {3'h0, vector_q}; // R7
  assign global_enable_counter_out = global_enable_counter_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data is registered, so it appears one cycle after the read strobe.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= PIC_RST_WORD;
    end else if (bus_in.rd) begin
      unique case (1'b1)
        addr_is(bus_in.addr, PIC_ENA0_LO): rdata_q <= low_priority_enable_q[15:0];
        addr_is(bus_in.addr, PIC_ENA0_HI): rdata_q <= high_priority_enable_q[15:0];
        addr_is(bus_in.addr, PIC_ENA1_LO): rdata_q <= 16'(low_priority_enable_q[NUM_SRC-1:16]);
        addr_is(bus_in.addr, PIC_ENA1_HI): rdata_q <= 16'(high_priority_enable_q[NUM_SRC-1:16]);
        addr_is(bus_in.addr, PIC_ORIGIN0): rdata_q <= origin_q[15:0]; // R10
        addr_is(bus_in.addr, PIC_ORIGIN1): rdata_q <= 16'(origin_q[NUM_SRC-1:16]); // R10
        addr_is(bus_in.addr, PIC_VECTOR): rdata_q <= {11'h000, vector_q}; // R12
        addr_is(bus_in.addr, PIC_ENCOUNT): rdata_q <= {13'h0000, global_enable_counter_q};
        default: rdata_q <= PIC_RST_WORD;
      endcase
    end
  end
  assign rdata_out = rdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_block_when_nonzero;
    @(posedge clock_in) disable iff (rst_in) global_enable_counter_q != 3'h0 |=> !strobe_q;
  endproperty
  a_block_when_nonzero: assert property (p_block_when_nonzero) else $error("strobe while counter nonzero"); // R11

  // A global enable write in the forwarding cycle cancels the increment, so a second forward may follow at once.
  property p_strobe_one;
    @(posedge clock_in) disable iff (rst_in) strobe_q |=> !strobe_q || $past(wr_ena, 2);
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe longer than one cycle"); // R14

  property p_fire_counts;
    @(posedge clock_in) disable iff (rst_in)
      fire && !wr_dis && !wr_ena |=> global_enable_counter_q == 3'h1;
  endproperty
  a_fire_counts: assert property (p_fire_counts) else $error("forward did not bump counter"); // R11

  property p_address;
    @(posedge clock_in) disable iff (rst_in) strobe_q |-> core_req_out.address == 8'h20 + {3'h0, vector_q};
  endproperty
  a_address: assert property (p_address) else $error("bad vector address"); // R7

  sequence s_fwd;
    fire ##1 strobe_q;
  endsequence
  property p_vector_kept;
    @(posedge clock_in) disable iff (rst_in) fire |=> vector_q == $past(best_vec);
  endproperty
  a_vector_kept: assert property (p_vector_kept) else $error("vector not latched"); // R12

  property p_flag_cleared;
    @(posedge clock_in) disable iff (rst_in) s_fwd |-> !origin_q[vector_q] || $past(src_live[best_vec]);
  endproperty
  a_flag_cleared: assert property (p_flag_cleared) else $error("forwarded flag kept"); // R10

  property p_disabled_silent;
    @(posedge clock_in) disable iff (rst_in)
      (high_priority_enable_q | low_priority_enable_q) == '0 |=> !strobe_q;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent) else $error("disabled source forwarded"); // R9

  property p_win_priority;
    @(posedge clock_in) disable iff (rst_in)
      fire && origin_q[NUM_SRC-1] && high_priority_enable_q[NUM_SRC-1] && low_priority_enable_q[NUM_SRC-1]
      |-> best_vec == 5'(NUM_SRC-1);
  endproperty
  a_win_priority: assert property (p_win_priority) else $error("top source lost arbitration"); // R13
endmodule
`default_nettype wire

// [core/pic_pkg.sv]
// Package of constants and carrier types for the prioritized interrupt controller.
package pic_pkg;
  // Source count and vector layout.
  localparam int unsigned PIC_NUM_SRC = 28;
  localparam int unsigned PIC_LOW_SRC = 16;
  localparam int unsigned PIC_VEC_W = 5;
  localparam int unsigned PIC_CNT_W = 3;
  // Core vector address base.
  localparam logic [7:0] PIC_VEC_BASE = 8'h20;
  // Mask of vectors that exist; vectors 5, 10 and 24 have no source.
  localparam logic [27:0] PIC_SRC_PRESENT = 28'hefffbdf;
  // Decode window of PLL-clocked and crystal-clocked peripherals in Y space.
  localparam logic [15:0] PIC_PLL_LO = 16'hfc00;
  localparam logic [15:0] PIC_PLL_HI = 16'hfd3f;
  localparam logic [15:0] PIC_XTAL_LO = 16'hfe00;
  localparam logic [15:0] PIC_XTAL_HI = 16'hfedf;
  localparam logic [15:0] PIC_BLOCK_LO = 16'hfc00;
  localparam logic [15:0] PIC_BLOCK_HI = 16'hfc1f;
  // Register word addresses.
  localparam logic [15:0] PIC_ENA0_LO = 16'hfc00;
  localparam logic [15:0] PIC_ENA1_LO = 16'hfc01;
  localparam logic [15:0] PIC_ENA0_HI = 16'hfc02;
  localparam logic [15:0] PIC_ENA1_HI = 16'hfc03;
  localparam logic [15:0] PIC_ORIGIN0 = 16'hfc04;
  localparam logic [15:0] PIC_ORIGIN1 = 16'hfc05;
  localparam logic [15:0] PIC_VECTOR = 16'hfc06;
  localparam logic [15:0] PIC_ENCOUNT = 16'hfc07;
  localparam logic [15:0] PIC_GLOB_DIS = 16'hfc08;
  localparam logic [15:0] PIC_GLOB_ENA = 16'hfc09;
  // Reset values.
  localparam logic [15:0] PIC_RST_WORD = 16'h0000;
  localparam logic [2:0] PIC_RST_CNT = 3'h0;
  localparam logic [4:0] PIC_RST_VEC = 5'h00;

  // Priority levels from the enable bit pairs.
  typedef enum logic [1:0] {
    PIC_PRI_OFF,
    PIC_PRI_LOW,
    PIC_PRI_MED,
    PIC_PRI_HIGH
  } pic_pri_e;

  // Y-space register access from the core.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pic_bus_s;

  // Vectored request to the core.
  typedef struct packed {
    logic strobe;
    logic [4:0] vector;
    logic [7:0] address;
  } pic_req_s;
endpackage

// [tb/pic_core_model.sv]
// Behavioural core that takes vectored requests and runs a short handler.
`timescale 1ns/1ns
`default_nettype none
module pic_core_model #(
  parameter int LAT = 3
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire pic_pkg::pic_req_s core_req_in,
  output logic done_out
);
  import pic_pkg::*;
  int left_q;
  // The handler restarts a LAT-cycle countdown on each strobe and then raises done_out; the bench writes the re-enable after that.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      left_q <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= (left_q == 1);
      left_q <= core_req_in.strobe ? LAT : ((left_q != 0) ? left_q - 1 : 0);
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the prioritized interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pic_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [27:0] src = '0;
  pic_bus_s bus = '0;
  logic [15:0] rdata;
  logic hit, done, rd_d;
  pic_req_s req;
  logic [2:0] cnt;
  logic [15:0] rq[$];
  logic [4:0] vq[$];
  logic [4:0] ev;
  int errors = 0;
  int checked = 0;
  logic [31:0] lf = 32'hbfa0;
  pic_ctrl pic_ctrl_i (.clock_in(clk), .rst_in(rst), .source_req_in(src), .bus_in(bus), .rdata_out(rdata),
    .hit_out(hit), .core_req_out(req), .global_enable_counter_out(cnt));
  pic_core_model pic_core_model_i (.clock_in(clk), .rst_in(rst), .core_req_in(req), .done_out(done));
  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One bus access; the idle cycle after it keeps two drives of bus out of one time step.
  task automatic acc(input logic r, input logic [15:0] a, input logic [15:0] d);
    bus <= '{rd: r, wr: !r, addr: a, wdata: d};
    #1 chk("hit", 16'(a >= PIC_BLOCK_LO && a <= PIC_BLOCK_HI), 16'(hit));
    @(negedge clk);
    bus <= '0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    rq.push_back(exp);
    acc(1'b1, a, 16'h0000);
  endtask
  task automatic pulse(input logic [27:0] m);
    src <= m;
    @(negedge clk);
    src <= '0;
    @(negedge clk);
  endtask
  // Wait for the handler to finish, then re-enable with a random data word.
  task automatic service();
    for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk);
    if (done !== 1'b1) begin
      errors++;
      close_out();
    end
    lf = lfsr(lf);
    acc(1'b0, PIC_GLOB_ENA, lf[15:0]);
  endtask
  // Note which cycles carry read data.
  always @(posedge clk) rd_d <= bus.rd;
  // Each result taken off the outputs is matched with the oldest note.
  always @(negedge clk) begin
    if (rd_d === 1'b1) chk("rdata", rq.size() ? rq.pop_front() : 16'hdead, rdata);
    if (req.strobe === 1'b1) begin
      ev = vq.size() ? vq.pop_front() : 5'h1f;
      chk("vector", 16'(ev), 16'(req.vector));
      chk("address", 16'(8'h20 + ev), 16'(req.address));
    end
  end
  // Main sequence.
  initial begin
    repeat (6) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("counter", 16'h0000, 16'(cnt));
    chk("address", 16'h0020, 16'(req.address));
    rd(PIC_VECTOR, 16'h0000);
    rd(16'hfc1f, 16'h0000);
    rd(16'hfc20, 16'h0000);
    $display("test reset done");
    acc(1'b0, PIC_ENA0_HI, 16'h0002);
    vq.push_back(5'd1);
    pulse(28'h0000002);
    service();
    chk("counter", 16'h0000, 16'(cnt));
    rd(PIC_VECTOR, 16'h0001);
    $display("test single done");
    lf = lfsr(lf);
    acc(1'b0, PIC_GLOB_DIS, lf[15:0]);
    chk("counter", 16'h0001, 16'(cnt));
    acc(1'b0, PIC_ENA0_LO, 16'h0018);
    acc(1'b0, PIC_ENA0_HI, 16'h0012);
    acc(1'b0, PIC_ENA1_HI, 16'h0008);
    pulse(28'h0080018);
    rd(PIC_ORIGIN0, 16'h0018);
    rd(PIC_ORIGIN1, 16'h0008);
    vq.push_back(5'd4);
    vq.push_back(5'd19);
    vq.push_back(5'd3);
    acc(1'b0, PIC_GLOB_ENA, 16'h0000);
    repeat (3) service();
    rd(PIC_ORIGIN0, 16'h0000);
    $display("test priority done");
    acc(1'b0, PIC_ENA0_LO, 16'h5018);
    acc(1'b0, PIC_ENA0_HI, 16'h0002);
    vq.push_back(5'd14);
    vq.push_back(5'd12);
    pulse(28'h0005000);
    repeat (2) service();
    $display("test tie done");
    acc(1'b0, PIC_ENA0_LO, 16'h5038);
    pulse(28'h0008021);
    rd(PIC_ORIGIN0, 16'h8001);
    acc(1'b0, PIC_ORIGIN0, 16'h0001);
    rd(PIC_ORIGIN0, 16'h8000);
    acc(1'b0, PIC_ORIGIN0, 16'h8000);
    rd(PIC_ORIGIN0, 16'h0000);
    $display("test flags done");
    acc(1'b0, PIC_GLOB_ENA, 16'h0000);
    chk("counter", 16'h0000, 16'(cnt));
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      acc(1'b0, PIC_GLOB_DIS, lf[15:0]);
    end
    acc(1'b0, PIC_ENCOUNT, 16'h0000);
    chk("counter", 16'h0003, 16'(cnt));
    rd(PIC_ENCOUNT, 16'h0003);
    repeat (3) acc(1'b0, PIC_GLOB_ENA, 16'h0000);
    chk("counter", 16'h0000, 16'(cnt));
    lf = lfsr(lf);
    acc(1'b0, PIC_ENA1_LO, lf[15:0]);
    rd(PIC_ENA1_LO, {4'h0, lf[11:0]});
    $display("test counter done");
    acc(1'b0, PIC_ENA1_LO, 16'h0c00);
    acc(1'b0, PIC_ENA1_HI, 16'h0c00);
    vq.push_back(5'd27);
    vq.push_back(5'd26);
    pulse(28'hc000000);
    repeat (2) service();
    chk("counter", 16'h0000, 16'(cnt));
    $display("test top done");
    // Random requests while the counter holds them back; absent vector slots must stay clear.
    lf = lfsr(lf);
    acc(1'b0, PIC_GLOB_DIS, lf[15:0]);
    lf = lfsr(lf);
    pulse(lf[27:0]);
    rd(PIC_ORIGIN0, lf[15:0] & PIC_SRC_PRESENT[15:0]);
    rd(PIC_ORIGIN1, {4'h0, lf[27:16] & PIC_SRC_PRESENT[27:16]});
    $display("test random done");
    // A second reset in mid-run must drop the held counter, the pending flags and the enables.
    rst <= 1'b1;
    repeat (2) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("counter", 16'h0000, 16'(cnt));
    rd(PIC_ORIGIN1, 16'h0000);
    rd(PIC_ENA1_HI, 16'h0000);
    $display("test reset again done");
    repeat (5) @(negedge clk);
    chk("pending", 16'h0000, 16'(vq.size() + rq.size()));
    close_out();
  end
endmodule
`default_nettype wire
